/* File: src/cas_pkg.sv */
`timescale 1ns/100ps
`default_nettype none

package cas_pkg;

   localparam int DATA_W = 8;
   localparam int FADDR_W = 7;
   localparam int FILE_DEPTH = 128;
   localparam int BUS_AW = 8;

   // Bus map: file registers of the current bank sit at 8'h00..8'h7f
   localparam logic [7:0] REG_WORK_OFS = 8'h80;
   localparam logic [7:0] REG_STATUS_OFS = 8'h81;
   localparam logic [7:0] REG_CORE_OFS = 8'h82;

   // Status bit positions
   localparam int ST_C = 0;
   localparam int ST_DC = 1;
   localparam int ST_Z = 2;
   localparam int ST_PD = 3;
   localparam int ST_TO = 4;

   localparam logic [7:0] STATUS_RST = 8'h18;
   localparam logic [7:0] STATUS_WR_MASK = 8'h07;
   localparam logic [7:0] WORK_RST = 8'h00;
   localparam logic [7:0] DEC_STEP = 8'h01;
   localparam logic [7:0] ZERO_BYTE = 8'h00;

   typedef enum logic [2:0] {
      CAS_OP_NOP = 3'b000,
      CAS_OP_DEC = 3'b001,
      CAS_OP_CLEAR_WORK_REG_OP = 3'b010,
      CAS_OP_RRF = 3'b011,
      CAS_OP_SUB_FROM_LITERAL_OP = 3'b100,
      CAS_OP_SUB_FROM_FILE_OP = 3'b101,
      CAS_OP_SLEEP = 3'b110
   } cas_op_t;

   typedef enum logic {
      CAS_RUN = 1'b0,
      CAS_ASLEEP = 1'b1
   } cas_state_t;

   // Returns {carry, digit_carry, a - b}; carry means no borrow
   function automatic logic [9:0] cas_sub(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] diff;
      diff = a - b;
      return {(b <= a), (b[3:0] <= a[3:0]), diff};
   endfunction : cas_sub

endpackage : cas_pkg

module cas_alu (
   input wire cas_pkg::cas_op_t op,
   input wire logic [7:0] file_val,
   input wire logic [7:0] work_val,
   input wire logic [7:0] literal,
   input wire logic carry_in,
   output logic [7:0] result,
   output logic c_out,
   output logic dc_out,
   output logic wr_c,
   output logic wr_dc,
   output logic wr_z,
   output logic res_valid
);
   import cas_pkg::*;

   logic [9:0] sub_res;

   always_comb begin
      sub_res = cas_sub(file_val, work_val);
      result = ZERO_BYTE;
      c_out = carry_in;
      dc_out = 1'h0;
      wr_c = 1'h0;
      wr_dc = 1'h0;
      wr_z = 1'h0;
      res_valid = 1'h0;
      case (op)
         CAS_OP_DEC: begin
            result = file_val - DEC_STEP;
            wr_z = 1'h1;
            res_valid = 1'h1;
         end
         CAS_OP_CLEAR_WORK_REG_OP: begin
            result = ZERO_BYTE;
            wr_z = 1'h1;
            res_valid = 1'h1;
         end
         CAS_OP_RRF: begin
            result = {carry_in, file_val[7:1]};
            c_out = file_val[0];
            wr_c = 1'h1;
            res_valid = 1'h1;
         end
         CAS_OP_SUB_FROM_LITERAL_OP: begin
            sub_res = cas_sub(literal, work_val);
            {c_out, dc_out, result} = sub_res;
            wr_c = 1'h1;
            wr_dc = 1'h1;
            wr_z = 1'h1;
            res_valid = 1'h1;
         end
         CAS_OP_SUB_FROM_FILE_OP: begin
            {c_out, dc_out, result} = sub_res;
            wr_c = 1'h1;
            wr_dc = 1'h1;
            wr_z = 1'h1;
            res_valid = 1'h1;
         end
         default: begin
            result = ZERO_BYTE;
         end
      endcase
   end

endmodule : cas_alu

`default_nettype wire

/* File: src/cas_core_exec.sv */
// Behaviour
// - Decrement file register; only zero flag changes
// - Clear working register and set zero
// - Rotate right through carry; only carry changes
// - Rotate result to working or file register
// - Literal minus working; carry means no borrow
// - Digit carry from low nibbles; zero updated
// - Literal is eight-bit unsigned, 0 to 255
// - File minus working; carry, digit carry, zero
// - Difference to working or file register
// - Sleep clears watchdog, sets timeout, clears powerdown
// - Sleep halts core with oscillator stopped
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/100ps
`default_nettype none

module cas_core_exec (
   input wire logic clock,
   input wire logic clk_en,
   input wire logic sys_rst,
   input wire logic op_valid,
   input wire cas_pkg::cas_op_t op_code,
   input wire logic [cas_pkg::FADDR_W-1:0] op_faddr,
   input wire logic op_dest,
   input wire logic [cas_pkg::DATA_W-1:0] op_literal,
   input wire logic wake_pin,
   input wire logic [cas_pkg::BUS_AW-1:0] bus_addr,
   input wire logic [cas_pkg::DATA_W-1:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [cas_pkg::DATA_W-1:0] bus_rdata,
   output logic [cas_pkg::DATA_W-1:0] work_reg,
   output logic [cas_pkg::DATA_W-1:0] status_reg,
   output logic osc_stop,
   output logic wdt_clear
);
   import cas_pkg::*;

   logic [DATA_W-1:0] file_mem [FILE_DEPTH];
   cas_state_t state;
   cas_state_t next_state;
   logic [1:0] wake_sync;
   logic [DATA_W-1:0] next_work_reg;
   logic [DATA_W-1:0] next_status_reg;
   logic [DATA_W-1:0] next_bus_rdata;
   logic next_osc_stop;
   logic next_wdt_clear;
   logic next_fwr_en;
   logic [FADDR_W-1:0] next_fwr_addr;
   logic [DATA_W-1:0] next_fwr_data;
   logic take;
   logic [DATA_W-1:0] file_val;
   logic [DATA_W-1:0] alu_result;
   logic alu_c;
   logic alu_dc;
   logic alu_wr_c;
   logic alu_wr_dc;
   logic alu_wr_z;
   logic alu_valid;
   logic bus_file_sel;

   // No instruction is taken while asleep
   assign take = op_valid && (state == CAS_RUN);
   // Seven-bit operand addresses the current bank
   assign file_val = file_mem[op_faddr];
   assign bus_file_sel = (bus_addr[7] == 1'h0);

   cas_alu u_alu (
      .op(op_code),
      .file_val(file_val),
      .work_val(work_reg),
      .literal(op_literal),
      .carry_in(status_reg[ST_C]),
      .result(alu_result),
      .c_out(alu_c),
      .dc_out(alu_dc),
      .wr_c(alu_wr_c),
      .wr_dc(alu_wr_dc),
      .wr_z(alu_wr_z),
      .res_valid(alu_valid)
   );

   // Wake pin synchroniser
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         wake_sync <= 2'h0;
      end else if (clk_en) begin
         wake_sync <= {wake_sync[0], wake_pin};
      end
   end

   // Sleep state and oscillator stop
   always_comb begin
      next_state = state;
      next_osc_stop = osc_stop;
      next_wdt_clear = 1'h0;
      case (state)
         CAS_RUN: begin
            if (take && op_code == CAS_OP_SLEEP) begin
               next_state = CAS_ASLEEP;
               next_osc_stop = 1'h1;
               next_wdt_clear = 1'h1;
            end
         end
         CAS_ASLEEP: begin
            if (wake_sync[1]) begin
               next_state = CAS_RUN;
               next_osc_stop = 1'h0;
            end
         end
         default: begin
            next_state = CAS_RUN;
            next_osc_stop = 1'h0;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state <= CAS_RUN;
         osc_stop <= 1'h0;
         wdt_clear <= 1'h0;
      end else if (clk_en) begin
         state <= next_state;
         osc_stop <= next_osc_stop;
         wdt_clear <= next_wdt_clear;
      end
   end

   // Working register, status and file write port
   always_comb begin
      next_work_reg = work_reg;
      next_status_reg = status_reg;
      next_fwr_en = 1'h0;
      next_fwr_addr = bus_addr[FADDR_W-1:0];
      next_fwr_data = bus_wdata;
      if (bus_wr) begin
         if (bus_file_sel) begin
            next_fwr_en = 1'h1;
         end else if (bus_addr == REG_WORK_OFS) begin
            next_work_reg = bus_wdata;
         end else if (bus_addr == REG_STATUS_OFS) begin
            next_status_reg = (status_reg & ~STATUS_WR_MASK) | (bus_wdata & STATUS_WR_MASK);
         end
      end
      if (take && alu_valid) begin
         if (op_dest && op_code != CAS_OP_CLEAR_WORK_REG_OP && op_code != CAS_OP_SUB_FROM_LITERAL_OP) begin
            next_fwr_en = 1'h1;
            next_fwr_addr = op_faddr;
            next_fwr_data = alu_result;
         end else begin
            next_work_reg = alu_result;
         end
         // Carry only where the operation owns it
         if (alu_wr_c) begin
            next_status_reg[ST_C] = alu_c;
         end
         if (alu_wr_dc) begin
            next_status_reg[ST_DC] = alu_dc;
         end
         if (alu_wr_z) begin
            next_status_reg[ST_Z] = (alu_result == ZERO_BYTE);
         end
      end
      if (take && op_code == CAS_OP_SLEEP) begin
         next_status_reg[ST_TO] = 1'h1;
         next_status_reg[ST_PD] = 1'h0;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         work_reg <= WORK_RST;
         status_reg <= STATUS_RST;
      end else if (clk_en) begin
         work_reg <= next_work_reg;
         status_reg <= next_status_reg;
      end
   end

   always_ff @(posedge clock) begin
      if (clk_en && next_fwr_en) begin
         file_mem[next_fwr_addr] <= next_fwr_data;
      end
   end

   // Read data stand one cycle only
   always_comb begin
      next_bus_rdata = ZERO_BYTE;
      if (bus_rd) begin
         if (bus_file_sel) begin
            next_bus_rdata = file_mem[bus_addr[FADDR_W-1:0]];
         end else if (bus_addr == REG_WORK_OFS) begin
            next_bus_rdata = work_reg;
         end else if (bus_addr == REG_STATUS_OFS) begin
            next_bus_rdata = status_reg;
         end else if (bus_addr == REG_CORE_OFS) begin
            next_bus_rdata = {7'h00, osc_stop};
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         bus_rdata <= ZERO_BYTE;
      end else if (clk_en) begin
         bus_rdata <= next_bus_rdata;
      end
   end

   AST_DEC_WORK: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && take && op_code == CAS_OP_DEC && !op_dest && !bus_wr
      |=> work_reg == $past(file_val) - 8'h01 && status_reg[1:0] == $past(status_reg[1:0])
         && status_reg[ST_Z] == (work_reg == 8'h00))
      else $error("decrement result or flags wrong");

   AST_CLEAR_WORK_REG_OP: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && take && op_code == CAS_OP_CLEAR_WORK_REG_OP
      |=> work_reg == 8'h00 && status_reg[ST_Z] && $stable(status_reg[ST_DC])
         && $stable(status_reg[ST_C]) && $stable(status_reg[ST_TO]))
      else $error("clear working register wrong");

   AST_RRF_CARRY: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && take && op_code == CAS_OP_RRF && !bus_wr
      |=> status_reg[ST_C] == $past(file_val[0]) && $stable(status_reg[ST_Z])
         && $stable(status_reg[ST_DC]))
      else $error("rotate carry wrong");

   AST_RRF_VALUE: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && take && op_code == CAS_OP_RRF && !op_dest
      |=> work_reg == {$past(status_reg[ST_C]), $past(file_val[7:1])})
      else $error("rotate value wrong");

   AST_DEST_FILE: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && take && op_dest && !bus_wr
      && (op_code == CAS_OP_RRF || op_code == CAS_OP_DEC || op_code == CAS_OP_SUB_FROM_FILE_OP)
      |-> next_fwr_en && next_fwr_addr == op_faddr ##1 $stable(work_reg))
      else $error("file destination not honoured");

   AST_SUB_FROM_LITERAL_OP: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && take && op_code == CAS_OP_SUB_FROM_LITERAL_OP
      |=> work_reg == $past(op_literal) - $past(work_reg)
         && status_reg[ST_C] == ($past(work_reg) <= $past(op_literal)))
      else $error("literal subtract wrong");

   // Digit carry and zero on literal subtract
   AST_SUB_FROM_LITERAL_OP_DC: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && take && op_code == CAS_OP_SUB_FROM_LITERAL_OP
      |=> status_reg[ST_DC] == ($past(work_reg[3:0]) <= $past(op_literal[3:0]))
         && status_reg[ST_Z] == (work_reg == 8'h00))
      else $error("literal subtract digit carry wrong");

   AST_SUB_FROM_FILE_OP: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && take && op_code == CAS_OP_SUB_FROM_FILE_OP && !op_dest && !bus_wr
      |=> work_reg == $past(file_val) - $past(work_reg)
         && status_reg[ST_C] == ($past(work_reg) <= $past(file_val))
         && status_reg[ST_DC] == ($past(work_reg[3:0]) <= $past(file_val[3:0])))
      else $error("file subtract wrong");

   AST_SLEEP_STATUS: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && take && op_code == CAS_OP_SLEEP
      |=> status_reg[ST_TO] && !status_reg[ST_PD] && wdt_clear)
      else $error("sleep status or watchdog clear wrong");

   AST_SLEEP_HALT: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && osc_stop && !wake_sync[1] && !bus_wr |=> osc_stop && $stable(work_reg))
      else $error("core ran while asleep");

   AST_ASLEEP_IDLE: assert property (@(posedge clock) disable iff (sys_rst)
      osc_stop |-> !take && state == CAS_ASLEEP)
      else $error("instruction taken while asleep");

   AST_SUB_FROM_FILE_OP_FILE: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && take && op_code == CAS_OP_SUB_FROM_FILE_OP && op_dest && !bus_wr
      |-> next_fwr_en && next_fwr_data == file_val - work_reg ##1 $stable(work_reg))
      else $error("file subtract destination wrong");

   AST_SUB_FROM_LITERAL_OP_LIT_MAX: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && take && op_code == CAS_OP_SUB_FROM_LITERAL_OP && op_literal == 8'hff
      |=> status_reg[ST_C] && work_reg == 8'hff - $past(work_reg))
      else $error("full-range literal treated as signed");

   AST_WDT_PULSE: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && wdt_clear |=> !wdt_clear)
      else $error("watchdog clear longer than one cycle");

endmodule : cas_core_exec

`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
   $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end

module tb_top;
   import cas_pkg::*;
   logic clock = 1'h0;
   logic clk_en = 1'h1;
   logic sys_rst = 1'h1;
   logic op_valid = 1'h0;
   cas_op_t op_code = CAS_OP_NOP;
   logic [6:0] op_faddr = 7'h00;
   logic op_dest = 1'h0;
   logic [7:0] op_literal = 8'h00;
   logic wake_pin = 1'h0;
   logic [7:0] bus_addr = 8'h00;
   logic [7:0] bus_wdata = 8'h00;
   logic bus_wr = 1'h0;
   logic bus_rd = 1'h0;
   logic [7:0] bus_rdata;
   logic [7:0] work_reg;
   logic [7:0] status_reg;
   logic osc_stop;
   logic wdt_clear;
   int err_count = 0;
   int tests_run = 0;
   logic [7:0] w;
   logic [7:0] k;
   logic [7:0] d;
   logic [7:0] wv [6] = '{8'h03, 8'h05, 8'h06, 8'hff, 8'h00, 8'h1f};
   logic [7:0] kv [6] = '{8'h05, 8'h05, 8'h05, 8'h00, 8'hff, 8'h20};

   always #4 clock = ~clock;

   cas_core_exec u_cas_core_exec (
      .clock(clock), .clk_en(clk_en), .sys_rst(sys_rst), .op_valid(op_valid),
      .op_code(op_code), .op_faddr(op_faddr), .op_dest(op_dest),
      .op_literal(op_literal), .wake_pin(wake_pin), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_rdata(bus_rdata), .work_reg(work_reg), .status_reg(status_reg),
      .osc_stop(osc_stop), .wdt_clear(wdt_clear)
   );

   // Expected status byte, timeout bit always set
   function automatic logic [7:0] st(input logic pd, input logic z, input logic dc,
                                     input logic c);
      return {3'h0, 1'h1, pd, z, dc, c};
   endfunction : st

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clock);
      bus_addr <= a;
      bus_wdata <= v;
      bus_wr <= 1'h1;
      @(posedge clock);
      bus_wr <= 1'h0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock);
      bus_addr <= a;
      bus_rd <= 1'h1;
      @(posedge clock);
      bus_rd <= 1'h0;
      #1;
      `CHK(bus_rdata, e)
   endtask : rd

   task automatic exec(input cas_op_t o, input logic [6:0] f, input logic dd,
                       input logic [7:0] l);
      @(posedge clock);
      op_code <= o;
      op_faddr <= f;
      op_dest <= dd;
      op_literal <= l;
      op_valid <= 1'h1;
      @(posedge clock);
      op_valid <= 1'h0;
      #1;
   endtask : exec

   // Known working value, status flags and one file byte before an op
   task automatic prep(input logic [7:0] wk, input logic [2:0] s, input logic [6:0] f,
                       input logic [7:0] fv);
      wr(8'h80, wk);
      wr(8'h81, {5'h00, s});
      wr({1'h0, f}, fv);
   endtask : prep

   task automatic results;
      $display("errors %0d, comparisons %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : results

   initial begin
      #100000;
      err_count++;
      results;
   end

   initial begin
      repeat (8) @(posedge clock);
      sys_rst <= 1'h0;
      #1;
      `CHK(work_reg, 8'h00)
      `CHK(status_reg, 8'h18)
      rd(8'h83, 8'h00);
      wr(8'h90, 8'h12);
      rd(8'h90, 8'h00);
      prep(8'h33, 3'h7, 7'h10, 8'h00);
      exec(CAS_OP_DEC, 7'h10, 1'h1, 8'h00);
      `CHK(status_reg, st(1'h1, 1'h0, 1'h1, 1'h1))
      `CHK(work_reg, 8'h33)
      rd(8'h10, 8'hff);
      prep(8'h33, 3'h0, 7'h11, 8'h01);
      exec(CAS_OP_DEC, 7'h11, 1'h0, 8'h00);
      `CHK(work_reg, 8'h00)
      `CHK(status_reg, st(1'h1, 1'h1, 1'h0, 1'h0))
      rd(8'h11, 8'h01);
      prep(8'h5a, 3'h3, 7'h12, 8'h00);
      exec(CAS_OP_CLEAR_WORK_REG_OP, 7'h12, 1'h1, 8'h00);
      `CHK(work_reg, 8'h00)
      `CHK(status_reg, st(1'h1, 1'h1, 1'h1, 1'h1))
      prep(8'h44, 3'h5, 7'h20, 8'h02);
      exec(CAS_OP_RRF, 7'h20, 1'h1, 8'h00);
      `CHK(status_reg, st(1'h1, 1'h1, 1'h0, 1'h0))
      `CHK(work_reg, 8'h44)
      rd(8'h20, 8'h81);
      prep(8'h44, 3'h2, 7'h21, 8'h01);
      exec(CAS_OP_RRF, 7'h21, 1'h0, 8'h00);
      `CHK(work_reg, 8'h00)
      `CHK(status_reg, st(1'h1, 1'h0, 1'h1, 1'h1))
      rd(8'h21, 8'h01);
      for (int i = 0; i < 6; i++) begin
         w = wv[i];
         k = kv[i];
         d = k - w;
         prep(w, 3'h0, 7'h00, 8'h00);
         exec(CAS_OP_SUB_FROM_LITERAL_OP, 7'h00, 1'h1, k);
         `CHK(work_reg, d)
         `CHK(status_reg, st(1'h1, d == 8'h00, w[3:0] <= k[3:0], w <= k))
         prep(w, 3'h0, 7'h7f, k);
         exec(CAS_OP_SUB_FROM_FILE_OP, 7'h7f, i[0], 8'h00);
         `CHK(status_reg, st(1'h1, d == 8'h00, w[3:0] <= k[3:0], w <= k))
         `CHK(work_reg, i[0] ? w : d)
         rd(8'h7f, i[0] ? d : k);
      end
      prep(8'h21, 3'h0, 7'h00, 8'h00);
      exec(cas_op_t'(3'h7), 7'h00, 1'h0, 8'h00);
      `CHK(work_reg, 8'h21)
      @(posedge clock);
      clk_en <= 1'h0;
      op_code <= CAS_OP_CLEAR_WORK_REG_OP;
      op_valid <= 1'h1;
      @(posedge clock);
      op_valid <= 1'h0;
      clk_en <= 1'h1;
      #1;
      `CHK(work_reg, 8'h21)
      exec(CAS_OP_SLEEP, 7'h00, 1'h0, 8'h00);
      `CHK(status_reg, st(1'h0, 1'h0, 1'h0, 1'h0))
      `CHK(wdt_clear, 1'h1)
      `CHK(osc_stop, 1'h1)
      @(posedge clock);
      #1;
      `CHK(wdt_clear, 1'h0)
      exec(CAS_OP_CLEAR_WORK_REG_OP, 7'h00, 1'h0, 8'h00);
      `CHK(work_reg, 8'h21)
      rd(8'h82, 8'h01);
      @(posedge clock);
      wake_pin <= 1'h1;
      for (int n = 0; n < 8 && osc_stop !== 1'h0; n++) begin
         @(posedge clock);
         #1;
      end
      `CHK(osc_stop, 1'h0)
      @(posedge clock);
      wake_pin <= 1'h0;
      rd(8'h82, 8'h00);
      exec(CAS_OP_CLEAR_WORK_REG_OP, 7'h00, 1'h0, 8'h00);
      `CHK(work_reg, 8'h00)
      results;
   end

endmodule : tb_top
`default_nettype wire
